// >>> rdaf_params.svh
// register offsets, field positions, reset values and constants of the rx address filter
`ifndef RDAF_PARAMS_SVH
`define RDAF_PARAMS_SVH

// byte addresses on the register bus, one aligned word each
`define RDAF_OFS_STATION0     8'h00
`define RDAF_OFS_HASH0        8'h18
`define RDAF_OFS_CONFIG       8'h38
`define RDAF_OFS_STATUS       8'h3C
`define RDAF_OFS_ACCEPTED     8'h40
`define RDAF_OFS_REJECTED     8'h44

// config register fields
`define RDAF_CFG_BCAST_BIT    0
`define RDAF_CFG_GROUP_BIT    1
`define RDAF_CFG_PROMISC_BIT  2
`define RDAF_CFG_RESET        3'h0

// status register fields
`define RDAF_STA_UNI_BIT      0
`define RDAF_STA_MUL_BIT      1
`define RDAF_STA_BRO_BIT      2
`define RDAF_STA_COMB_BIT     3
`define RDAF_STA_BUSY_BIT     4
`define RDAF_STA_HASH_LSB     8

// address field geometry
`define RDAF_ADDR_BYTES       6
`define RDAF_HASH_BYTES       8
`define RDAF_LAST_BIT         6'h2F
`define RDAF_REG_RESET        8'h00

// crc generator
`define RDAF_CRC_INIT         32'hFFFFFFFF
`define RDAF_CRC_POLY         32'h04C11DB7
`define RDAF_HASH_MSB         31
`define RDAF_HASH_LSB         26

`endif

// >>> rdaf_pkg.sv
// types shared by the rx destination address filter
package rdaf_pkg;

    // one received bit from the mac receive path
    typedef struct packed {
        logic sof;
        logic valid;
        logic data;
    } rdaf_rx_bit_t;

    // match results of one frame
    typedef struct packed {
        logic combined_hit;
        logic broadcast;
        logic multicast;
        logic unicast;
    } rdaf_match_t;

    // receive sequencer states, one-hot
    typedef enum logic [3:0] {
        RDAF_ST_IDLE = 4'b0001,
        RDAF_ST_ADDR = 4'b0010,
        RDAF_ST_EVAL = 4'b0100,
        RDAF_ST_TAIL = 4'b1000
    } rdaf_state_t;

endpackage

// >>> rdaf_crc32_serial.sv
// serial crc generator, one bit per enabled cycle
`timescale 1ns/10ps
`include "rdaf_params.svh"

module rdaf_crc32_serial #(
    parameter int          WIDTH = 32,
    parameter logic [31:0] POLY  = `RDAF_CRC_POLY,
    parameter logic [31:0] INIT  = `RDAF_CRC_INIT
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             clear_i,
    input  wire logic             enable_i,
    input  wire logic             data_i,
    output logic [WIDTH-1:0]      crc_o
);

    logic [WIDTH-1:0] seed;
    logic             feedback;
    logic [WIDTH-1:0] next_crc;

    // a clear restarts from the preset value with the same bit already folded in
    assign seed     = clear_i ? INIT[WIDTH-1:0] : crc_o;
    assign feedback = seed[WIDTH-1] ^ data_i;
    assign next_crc = {seed[WIDTH-2:0], 1'b0} ^ (feedback ? POLY[WIDTH-1:0] : {WIDTH{1'b0}});

    // crc state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crc_o <= INIT[WIDTH-1:0];
        end else if (enable_i) begin
            crc_o <= next_crc;
        end
    end

endmodule

// >>> rdaf_filter.sv
// rx destination address filter with wishbone register slave
// Operation
// - first six frame bytes are the destination; any byte mismatch means no unicast hit
// - station byte k holds destination bits 8k..8k+7, lowest bit at D0, bit 0 first
// - station compare is done one whole byte at a time
// - destination runs through a 32-bit crc; top six bits latched after last bit
// - six-bit hash picks one of 64 table bits; multicast hits only when it is one
// - hash N selects table bit N, in hash byte N/8 at bit N mod 8
// - first received destination bit one marks multicast; hash applies only then
// - all 48 destination bits one raises the broadcast result
// - four one-bit results: unicast, multicast, broadcast, combined; one means matched
// - final decision uses the three match results with the three accept options
`timescale 1ns/10ps
`include "rdaf_params.svh"

module rdaf_filter
    import rdaf_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // mac receive bit stream
    input  wire rdaf_rx_bit_t rx_i,
    // wishbone classic slave
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic [31:0]       wb_dat_o,
    output logic              wb_ack_o,
    // frame decision
    output rdaf_match_t       match_o,
    output logic              match_valid_o
);

    // programmed registers
    logic [7:0]       station_address_byte [`RDAF_ADDR_BYTES];
    logic [7:0]       group_hash_byte      [`RDAF_HASH_BYTES];
    logic             accept_all_stations_frames;
    logic             accept_group_frames;
    logic             promiscuous_accept;
    logic [CNT_W-1:0] accepted_count;
    logic [CNT_W-1:0] rejected_count;

    // receive state
    rdaf_state_t      state;
    logic [5:0]       bit_cnt;
    logic [7:0]       byte_sr;
    logic             unicast_ok;
    logic             all_ones;
    logic             group_addr;
    logic [5:0]       hash_q;
    logic [31:0]      crc_q;

    // bus decode wires
    logic             bus_req;
    logic             wr_en;
    logic             aligned;
    logic [7:0]       sta_rel;
    logic [7:0]       hash_rel;
    logic [2:0]       sta_idx;
    logic [2:0]       hash_idx;
    logic             sta_hit;
    logic             hash_hit;
    logic             cfg_hit;
    logic             status_hit;
    logic             acc_hit;
    logic             rej_hit;
    logic [31:0]      cfg_word;
    logic [31:0]      status_word;
    logic [31:0]      rd_word;

    // receive datapath wires
    logic             busy;
    logic             take_bit;
    logic             first_bit;
    logic [5:0]       cur_idx;
    logic [2:0]       cur_byte;
    logic             byte_done;
    logic [7:0]       next_byte;
    logic             byte_equal;
    logic             next_unicast_ok;
    logic             next_all_ones;
    logic             next_group_addr;
    logic             last_bit;
    logic [5:0]       hash_now;
    logic             table_bit;
    rdaf_match_t      next_match;

    // a new request is one the slave has not yet answered; a write lands on the edge that sees ack high
    assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign aligned  = (wb_adr_i[1:0] == 2'h0);

    // register window decode; misaligned addresses fall to the unmapped answer
    assign sta_rel    = wb_adr_i - `RDAF_OFS_STATION0;
    assign hash_rel   = wb_adr_i - `RDAF_OFS_HASH0;
    assign sta_idx    = sta_rel[4:2];
    assign hash_idx   = hash_rel[4:2];
    assign sta_hit    = aligned & (wb_adr_i < `RDAF_OFS_HASH0);
    assign hash_hit   = aligned & (wb_adr_i >= `RDAF_OFS_HASH0) & (wb_adr_i < `RDAF_OFS_CONFIG);
    assign cfg_hit    = (wb_adr_i == `RDAF_OFS_CONFIG);
    assign status_hit = (wb_adr_i == `RDAF_OFS_STATUS);
    assign acc_hit    = (wb_adr_i == `RDAF_OFS_ACCEPTED);
    assign rej_hit    = (wb_adr_i == `RDAF_OFS_REJECTED);

    // config and status words, unused bits read zero
    always_comb begin
        cfg_word = 32'h0;
        cfg_word[`RDAF_CFG_BCAST_BIT]   = accept_all_stations_frames;
        cfg_word[`RDAF_CFG_GROUP_BIT]   = accept_group_frames;
        cfg_word[`RDAF_CFG_PROMISC_BIT] = promiscuous_accept;
    end

    always_comb begin
        status_word = 32'h0;
        status_word[`RDAF_STA_UNI_BIT]  = match_o.unicast;
        status_word[`RDAF_STA_MUL_BIT]  = match_o.multicast;
        status_word[`RDAF_STA_BRO_BIT]  = match_o.broadcast;
        status_word[`RDAF_STA_COMB_BIT] = match_o.combined_hit;
        status_word[`RDAF_STA_BUSY_BIT] = busy;
        status_word[`RDAF_STA_HASH_LSB +: 6] = hash_q;
    end

    // read selection; an unmapped address answers with zero
    assign rd_word = sta_hit    ? {24'h0, station_address_byte[sta_idx]} :
                     hash_hit   ? {24'h0, group_hash_byte[hash_idx]} :
                     cfg_hit    ? cfg_word :
                     status_hit ? status_word :
                     acc_hit    ? {{(32-CNT_W){1'b0}}, accepted_count} :
                     rej_hit    ? {{(32-CNT_W){1'b0}}, rejected_count} :
                     32'h0;

    // one wait state: ack the cycle after the request, drop it the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd_word;
            end
        end
    end

    // station address bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `RDAF_ADDR_BYTES; i++) begin
                station_address_byte[i] <= `RDAF_REG_RESET;
            end
        end else if (wr_en && sta_hit) begin
            station_address_byte[sta_idx] <= wb_dat_i[7:0];
        end
    end

    // group hash table bytes; writing all ones opens every multicast group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `RDAF_HASH_BYTES; i++) begin
                group_hash_byte[i] <= `RDAF_REG_RESET;
            end
        end else if (wr_en && hash_hit) begin
            group_hash_byte[hash_idx] <= wb_dat_i[7:0];
        end
    end

    // accept options
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {promiscuous_accept, accept_group_frames, accept_all_stations_frames} <= `RDAF_CFG_RESET;
        end else if (wr_en && cfg_hit) begin
            accept_all_stations_frames <= wb_dat_i[`RDAF_CFG_BCAST_BIT];
            accept_group_frames        <= wb_dat_i[`RDAF_CFG_GROUP_BIT];
            promiscuous_accept         <= wb_dat_i[`RDAF_CFG_PROMISC_BIT];
        end
    end

    // a start of frame restarts the walk at any time except the single evaluation cycle
    assign busy      = (state == RDAF_ST_ADDR) || (state == RDAF_ST_EVAL);
    assign first_bit = rx_i.sof;
    assign take_bit  = rx_i.valid & (first_bit ? (state != RDAF_ST_EVAL) : (state == RDAF_ST_ADDR));
    assign cur_idx   = first_bit ? 6'h00 : bit_cnt;
    assign cur_byte  = cur_idx[5:3];
    assign byte_done = (cur_idx[2:0] == 3'h7);
    assign last_bit  = take_bit & (cur_idx == `RDAF_LAST_BIT);

    // bits arrive lowest first, so each new bit enters at the top and slides down to D0
    assign next_byte  = {rx_i.data, first_bit ? 7'h00 : byte_sr[7:1]};
    assign byte_equal = (next_byte == station_address_byte[cur_byte]);

    // any byte that differs kills the unicast hit for the rest of the frame
    assign next_unicast_ok = (first_bit | unicast_ok) & (~byte_done | byte_equal);
    assign next_all_ones   = (first_bit | all_ones) & rx_i.data;
    assign next_group_addr = first_bit ? rx_i.data : group_addr;

    // crc over the destination field only; hash is read from it in the evaluation cycle
    rdaf_crc32_serial #(
        .WIDTH (32),
        .POLY  (`RDAF_CRC_POLY),
        .INIT  (`RDAF_CRC_INIT)
    ) u_crc (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (first_bit),
        .enable_i (take_bit),
        .data_i   (rx_i.data),
        .crc_o    (crc_q)
    );

    // one-of-64 table pick: byte hash/8, bit hash mod 8
    assign hash_now  = crc_q[`RDAF_HASH_MSB:`RDAF_HASH_LSB];
    assign table_bit = group_hash_byte[hash_now[5:3]][hash_now[2:0]];

    // match results and the combined decision
    always_comb begin
        next_match.unicast      = unicast_ok;
        next_match.multicast    = group_addr & table_bit;
        next_match.broadcast    = all_ones;
        next_match.combined_hit = unicast_ok
                                | (next_match.multicast & accept_group_frames)
                                | (all_ones & accept_all_stations_frames)
                                | promiscuous_accept;
    end

    // receive sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= RDAF_ST_IDLE;
        end else begin
            case (state)
                RDAF_ST_IDLE, RDAF_ST_ADDR, RDAF_ST_TAIL: begin
                    if (last_bit) begin
                        state <= RDAF_ST_EVAL;
                    end else if (take_bit) begin
                        state <= RDAF_ST_ADDR;
                    end
                end
                RDAF_ST_EVAL: begin
                    state <= RDAF_ST_TAIL;
                end
                default: begin
                    state <= RDAF_ST_IDLE;
                end
            endcase
        end
    end

    // destination field accumulators
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_cnt    <= 6'h00;
            byte_sr    <= 8'h00;
            unicast_ok <= 1'b0;
            all_ones   <= 1'b0;
            group_addr <= 1'b0;
        end else if (take_bit) begin
            bit_cnt    <= cur_idx + 6'h01;
            byte_sr    <= next_byte;
            unicast_ok <= next_unicast_ok;
            all_ones   <= next_all_ones;
            group_addr <= next_group_addr;
        end
    end

    // results stay until the next frame is judged; valid is high for the one cycle after the judging cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_o       <= '0;
            match_valid_o <= 1'b0;
            hash_q        <= 6'h00;
        end else begin
            match_valid_o <= (state == RDAF_ST_EVAL);
            if (state == RDAF_ST_EVAL) begin
                match_o <= next_match;
                hash_q  <= hash_now;
            end
        end
    end

    // frame counters; a count that lands on the clearing write is kept as one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accepted_count <= '0;
            rejected_count <= '0;
        end else begin
            if (state == RDAF_ST_EVAL && next_match.combined_hit) begin
                accepted_count <= (wr_en && acc_hit) ? CNT_W'(1) : accepted_count + CNT_W'(1);
            end else if (wr_en && acc_hit) begin
                accepted_count <= '0;
            end
            if (state == RDAF_ST_EVAL && !next_match.combined_hit) begin
                rejected_count <= (wr_en && rej_hit) ? CNT_W'(1) : rejected_count + CNT_W'(1);
            end else if (wr_en && rej_hit) begin
                rejected_count <= '0;
            end
        end
    end

endmodule

// >>> rdaf_filter_asserts.sv
// concurrent checks on the ports of the rx address filter
`timescale 1ns/10ps
`include "rdaf_params.svh"
module rdaf_filter_asserts
    import rdaf_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire rdaf_rx_bit_t rx_i,
    input wire logic         wb_cyc_i,
    input wire logic         wb_stb_i,
    input wire logic         wb_we_i,
    input wire logic [7:0]   wb_adr_i,
    input wire logic [3:0]   wb_sel_i,
    input wire logic [31:0]  wb_dat_i,
    input wire logic [31:0]  wb_dat_o,
    input wire logic         wb_ack_o,
    input wire rdaf_match_t  match_o,
    input wire logic         match_valid_o
);
    logic [5:0]  cnt;
    logic [47:0] da;
    logic [47:0] sta;
    logic [2:0]  cfg;
    logic        ones;
    wire         take_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire         wr_w   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    wire         sof_w  = rx_i.valid && rx_i.sof && cnt != 6'd48;
    wire         bit_w  = rx_i.valid && !sof_w && cnt != 6'd0 && cnt < 6'd48;

    // shadow of the destination and of the written station and config registers; a sof in the judging cycle is ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt  <= '0;
            da   <= '0;
            sta  <= '0;
            cfg  <= '0;
            ones <= 1'b0;
        end else begin
            if (sof_w) begin
                cnt  <= 6'd1;
                da   <= {47'h0, rx_i.data};
                ones <= rx_i.data;
            end else if (bit_w) begin
                cnt     <= cnt + 6'd1;
                da[cnt] <= rx_i.data;
                ones    <= ones & rx_i.data;
            end else if (cnt == 6'd48) begin
                cnt <= '0;
            end
            if (wr_w && wb_adr_i < `RDAF_OFS_HASH0 && wb_adr_i[1:0] == 2'b00) begin
                sta[{wb_adr_i[4:2], 3'b000} +: 8] <= wb_dat_i[7:0];
            end
            if (wr_w && wb_adr_i == `RDAF_OFS_CONFIG) begin
                cfg <= wb_dat_i[2:0];
            end
        end
    end

    sequence s_take;
        take_w;
    endsequence
    sequence s_last_bit;
        bit_w && cnt == 6'd47;
    endsequence
    sequence s_result;
        match_valid_o;
    endsequence

    property p_ack_answer;
        @(posedge clk_i) disable iff (rst_i) s_take |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered next cycle");
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_result_time;
        @(posedge clk_i) disable iff (rst_i) s_last_bit |-> ##2 s_result;
    endproperty
    a_result_time: assert property (p_result_time) else $error("result not two cycles after last bit");
    property p_valid_pulse;
        @(posedge clk_i) disable iff (rst_i) s_result |=> !match_valid_o;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("result strobe too long");
    property p_hold;
        @(posedge clk_i) disable iff (rst_i) !match_valid_o |-> $stable(match_o);
    endproperty
    a_hold: assert property (p_hold) else $error("results changed without strobe");
    property p_unicast;
        @(posedge clk_i) disable iff (rst_i) s_result |-> match_o.unicast == (da == sta);
    endproperty
    a_unicast: assert property (p_unicast) else $error("station match wrong");
    property p_broadcast;
        @(posedge clk_i) disable iff (rst_i) s_result |-> match_o.broadcast == ones;
    endproperty
    a_broadcast: assert property (p_broadcast) else $error("all ones match wrong");
    property p_group;
        @(posedge clk_i) disable iff (rst_i) match_valid_o && !da[0] |-> !match_o.multicast;
    endproperty
    a_group: assert property (p_group) else $error("group match on individual address");
    property p_combined;
        @(posedge clk_i) disable iff (rst_i) s_result |-> match_o.combined_hit == (match_o.unicast
            | (match_o.multicast & cfg[1]) | (match_o.broadcast & cfg[0]) | cfg[2]);
    endproperty
    a_combined: assert property (p_combined) else $error("combined decision wrong");
endmodule

bind rdaf_filter rdaf_filter_asserts #(.CNT_W(CNT_W)) u_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .rx_i(rx_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .match_o(match_o), .match_valid_o(match_valid_o));

// >>> rdaf_rx_src.sv
// behavioural mac receive source sending one destination address, bit 0 first
`timescale 1ns/10ps
module rdaf_rx_src
    import rdaf_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [47:0] da_i,
    input  wire logic        go_i,
    input  wire logic        gap_i,
    output rdaf_rx_bit_t     rx_o = '0
);
    logic [47:0] da   = '0;
    logic [5:0]  idx  = '0;
    logic        busy = 1'b0;
    logic        hold = 1'b0;

    // one bit a cycle, or every other cycle with gaps; idle data toggles so no stale bit looks valid
    always @(posedge clk_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            rx_o <= '0;
        end else if (go_i) begin
            busy       <= 1'b1;
            idx        <= '0;
            hold       <= 1'b0;
            da         <= da_i;
            rx_o.valid <= 1'b0;
        end else if (busy && !hold) begin
            rx_o.sof   <= (idx == 6'd0);
            rx_o.valid <= 1'b1;
            rx_o.data  <= da[idx];
            idx        <= idx + 6'd1;
            busy       <= (idx != 6'd47);
            hold       <= gap_i;
        end else begin
            rx_o.sof   <= 1'b0;
            rx_o.valid <= 1'b0;
            rx_o.data  <= ~rx_o.data;
            hold       <= 1'b0;
        end
    end
endmodule

// >>> rdaf_filter_tb.sv
// self-checking bench of the rx destination address filter
`timescale 1ns/10ps
`include "rdaf_params.svh"
module rdaf_filter_tb
    import rdaf_pkg::*;
;
    localparam logic [47:0] STA = 48'hBC9A_7856_3412;
    localparam logic [47:0] MC  = 48'h4433_2211_5E01;
    localparam logic [47:0] MC2 = 48'h0706_0504_0303;
    logic         clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]   wb_adr_i = '0;
    logic [3:0]   wb_sel_i = '0;
    logic [31:0]  wb_dat_i = '0, wb_dat_o, rd;
    logic         wb_ack_o, match_valid_o, go = 1'b0, gap = 1'b0;
    logic [47:0]  da = '0;
    logic [63:0]  tbl = '0;
    rdaf_rx_bit_t rx_i;
    rdaf_match_t  match_o;
    int           n_mismatch = 0, total_checks = 0, cycles = 0, n_acc = 0, n_rej = 0;

    rdaf_filter u_dut (.clk_i(clk_i), .rst_i(rst_i), .rx_i(rx_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .match_o(match_o), .match_valid_o(match_valid_o));
    rdaf_rx_src u_src (.clk_i(clk_i), .rst_i(rst_i), .da_i(da), .go_i(go), .gap_i(gap), .rx_o(rx_i));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // a run far past the roughly 1500 cycles expected is a hang
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 10000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_match(input rdaf_match_t exp, input rdaf_match_t got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] match_o expected %b seen %b", exp, got);
        end
    endtask

    // classic single cycle; entered right after a rising edge, waits for ack, then idles a cycle
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wb_read(input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0);
        chk_reg($sformatf("reg_%h", adr), exp, rd);
    endtask

    task automatic set_hash(input int k, input logic [7:0] v);
        wb_cycle(1'b1, `RDAF_OFS_HASH0 + 8'(4 * k), {24'h0, v});
        tbl[8 * k +: 8] = v;
    endtask

    // reference hash: serial crc, destination bit 0 first, top six bits kept
    function automatic logic [5:0] hash_of(input logic [47:0] a);
        logic [31:0] c;
        c = `RDAF_CRC_INIT;
        for (int i = 0; i < 48; i++) c = {c[30:0], 1'b0} ^ ((a[i] ^ c[31]) ? `RDAF_CRC_POLY : 32'h0);
        return c[31:26];
    endfunction

    // one frame under a given accept setting; results and status judged against the reference
    task automatic frame(input logic [47:0] a, input logic [2:0] cfg, input logic g);
        rdaf_match_t e;
        logic [5:0]  h;
        h              = hash_of(a);
        e.unicast      = (a == STA);
        e.broadcast    = &a;
        e.multicast    = a[0] & tbl[h];
        e.combined_hit = e.unicast | (e.multicast & cfg[1]) | (e.broadcast & cfg[0]) | cfg[2];
        wb_cycle(1'b1, `RDAF_OFS_CONFIG, {29'h0, cfg});
        da  <= a;
        gap <= g;
        go  <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        do @(posedge clk_i); while (match_valid_o !== 1'b1);
        chk_match(e, match_o);
        if (e.combined_hit) n_acc++;
        else n_rej++;
        wb_cycle(1'b0, `RDAF_OFS_STATUS, 32'h0);
        chk_reg("status", {18'h0, h, 4'h0, e}, rd);
    endtask

    initial begin
        logic [5:0] h;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 16; i++) wb_read(8'(4 * i), 32'h0);
        for (int i = 0; i < 14; i++) wb_cycle(1'b1, 8'(4 * i), 32'hFFFF_FF00 | 32'(i * 17));
        for (int i = 0; i < 14; i++) wb_read(8'(4 * i), 32'(i * 17));
        wb_cycle(1'b1, 8'h80, 32'h5A);
        wb_read(8'h80, 32'h0);
        wb_cycle(1'b1, `RDAF_OFS_STATUS, 32'hFF);
        wb_read(`RDAF_OFS_STATUS, 32'h0);
        for (int k = 0; k < 6; k++) wb_cycle(1'b1, 8'(4 * k), {24'h0, STA[8 * k +: 8]});
        wb_cycle(1'b1, 8'h01, 32'hAA);
        wb_read(8'h00, 32'h12);
        wb_read(8'h01, 32'h0);
        for (int k = 0; k < 8; k++) set_hash(k, 8'h00);
        frame(STA, 3'h0, 1'b0);
        frame(STA ^ 48'h8000_0000_0000, 3'h0, 1'b1);
        frame(STA ^ 48'h0000_0000_0002, 3'h0, 1'b0);
        frame(MC, 3'h2, 1'b0);
        h = hash_of(MC);
        set_hash(int'(h[5:3]), 8'h01 << h[2:0]);
        frame(MC, 3'h2, 1'b1);
        frame(MC2, 3'h2, 1'b0);
        frame(MC, 3'h0, 1'b0);
        for (int k = 0; k < 8; k++) set_hash(k, 8'hFF);
        frame(MC2, 3'h2, 1'b0);
        for (int c = 0; c < 8; c++) frame(48'hFFFF_FFFF_FFFF, 3'(c), c[0]);
        frame(48'hFFFF_FFFF_FFFE, 3'h7, 1'b0);
        wb_read(`RDAF_OFS_ACCEPTED, 32'(n_acc));
        wb_read(`RDAF_OFS_REJECTED, 32'(n_rej));
        wb_cycle(1'b1, `RDAF_OFS_ACCEPTED, 32'h0);
        wb_read(`RDAF_OFS_ACCEPTED, 32'h0);
        wb_cycle(1'b1, `RDAF_OFS_REJECTED, 32'h0);
        wb_read(`RDAF_OFS_REJECTED, 32'h0);
        stop_test();
    end
endmodule
